/* sfp_consts.svh */
// Constants of the sector flash program controller
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

// Register byte offsets
`define SFP_REG_ADDR      8'h00
`define SFP_REG_WDATA     8'h04
`define SFP_REG_CMD       8'h08
`define SFP_REG_STAT      8'h0c
`define SFP_REG_RDATA     8'h10

// Status fields
`define SFP_ST_BUSY       0
`define SFP_ST_LOAD_OPEN  1
`define SFP_ST_PROG       2
`define SFP_ST_STICKY_LSB 3
`define SFP_ST_LCNT_LSB   8

// Sticky flag positions inside the sticky group
`define SFP_FL_DONE       0
`define SFP_FL_TMO        1
`define SFP_FL_SECT_ERR   2
`define SFP_FL_PARTIAL    3

// Reset values
`define SFP_ADDR_RST      19'h00000
`define SFP_BYTE_RST      8'h00
`define SFP_STICKY_RST    4'h0

// Sector geometry
`define SFP_SECTOR_BYTES  9'h100
`define SFP_CMD_ADDR_MSB  14

// Timing in printed units and derived cycle counts
`define SFP_CLK_MHZ       200
`define SFP_AS_NS         10
`define SFP_WP_NS         90
`define SFP_DH_NS         10
`define SFP_WPH_NS        100
`define SFP_ACC_NS        90
`define SFP_OEHP_NS       150
`define SFP_BLC_US        150
`define SFP_WC_MS         10
`define SFP_NS2CYC(ns)    (((ns) * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_AS_CYC        `SFP_NS2CYC(`SFP_AS_NS)
`define SFP_WP_CYC        `SFP_NS2CYC(`SFP_WP_NS)
`define SFP_DH_CYC        `SFP_NS2CYC(`SFP_DH_NS)
`define SFP_WPH_CYC       `SFP_NS2CYC(`SFP_WPH_NS)
`define SFP_ACC_CYC       `SFP_NS2CYC(`SFP_ACC_NS)
`define SFP_OEHP_CYC      `SFP_NS2CYC(`SFP_OEHP_NS)
`define SFP_BLC_CYC       (`SFP_BLC_US * `SFP_CLK_MHZ)
`define SFP_WC_CYC        (`SFP_WC_MS * `SFP_CLK_MHZ * 1000)

`endif

/* sfp_pkg.sv */
// Types of the sector flash program controller
package sfp_pkg;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_SETUP  = 5'h02,
        ST_STROBE = 5'h04,
        ST_HOLD   = 5'h08,
        ST_REC    = 5'h10
    } sfp_state_e;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_LOAD = 2'h1,
        OP_CMDW = 2'h2,
        OP_POLL = 2'h3
    } sfp_op_e;

endpackage

/* sfp_interval_timer.sv */
// Interval timer that flags the end of a programmable count
module sfp_interval_timer #(
    parameter int LIMIT = 30000
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_start,
    output logic      o_run,
    output logic      o_expired
);
    localparam int W = $clog2(LIMIT + 1);

    generate
        if (LIMIT < 2) begin : g_bad_limit
            $error("sfp_interval_timer: LIMIT must be at least 2");
        end
    endgenerate

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         run_q;
    logic         run_d;
    logic         exp_q;
    logic         exp_d;

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (i_start) begin
            cnt_d = '0;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q == W'(LIMIT - 1)) begin
                run_d = 1'b0;
                exp_d = 1'b1;
            end else begin
                cnt_d = cnt_q + W'(1);
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end

    assign o_run     = run_q;
    assign o_expired = exp_q;
endmodule

/* sfp_toggle_track.sv */
// Tracks successive toggle bit samples and reports when they agree
module sfp_toggle_track (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_clear,
    input  wire logic i_sample,
    input  wire logic i_bit,
    output logic      o_stable
);
    logic prev_q;
    logic prev_d;
    logic valid_q;
    logic valid_d;
    logic stable_q;
    logic stable_d;

    always_comb begin
        prev_d   = prev_q;
        valid_d  = valid_q;
        stable_d = stable_q;
        if (i_clear) begin
            valid_d  = 1'b0;
            stable_d = 1'b0;
        end else if (i_sample) begin
            stable_d = valid_q && (i_bit == prev_q);
            prev_d   = i_bit;
            valid_d  = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            prev_q   <= 1'b0;
            valid_q  <= 1'b0;
            stable_q <= 1'b0;
        end else if (i_ce) begin
            prev_q   <= prev_d;
            valid_q  <= valid_d;
            stable_q <= stable_d;
        end
    end

    assign o_stable = stable_q;
endmodule

/* sfp_host_ctrl.sv */
// Host controller driving a parallel sector flash from Wishbone registers
//
// Chosen here: the Wishbone interface to the registers and the address map.
`include "sfp_consts.svh"
module sfp_host_ctrl #(
    parameter int P_WINDOW_CYC = `SFP_BLC_CYC,
    parameter int P_PROG_CYC   = `SFP_WC_CYC
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_ce_n,
    output logic             o_oe_n,
    output logic             o_we_n,
    output logic      [18:0] o_addr,
    output logic      [7:0]  o_dq_o,
    output logic             o_dq_oe_n,
    input  wire logic [7:0]  i_dq_i
);
    generate
        if (P_WINDOW_CYC < 2 || P_PROG_CYC < 2) begin : g_bad_params
            $error("sfp_host_ctrl: timer counts must be at least 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    sfp_pkg::sfp_state_e state_q, state_d;
    sfp_pkg::sfp_op_e    op_q, op_d;
    logic [7:0]  cnt_q, cnt_d;
    logic [18:0] addr_q, addr_d;
    logic [7:0]  wdata_q, wdata_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [10:0] sector_q, sector_d;
    logic [8:0]  lcnt_q, lcnt_d;
    logic        lopen_q, lopen_d;
    logic        prog_q, prog_d;
    logic [3:0]  sticky_q, sticky_d, sticky_set, sticky_clr;
    logic        ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
    logic [18:0] pa_q, pa_d;
    logic [7:0]  dqo_q, dqo_d;
    logic        dqoe_n_q, dqoe_n_d;
    logic        ack_q, ack_d;
    logic [31:0] wbd_q, wbd_d;
    logic        wb_req, wb_wr, start;
    logic        is_rd;
    logic [31:0] status;
    logic        win_start, win_exp, prog_start, prog_exp;
    logic        tog_clear, tog_sample, tog_stable;

    ////////////////////////////////////////////////////////////////////////////
    // Timers and toggle tracking
    sfp_interval_timer #(.LIMIT(P_WINDOW_CYC)) u_win_timer (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_start    (win_start),
        .o_run      (),
        .o_expired  (win_exp)
    );

    sfp_interval_timer #(.LIMIT(P_PROG_CYC)) u_prog_timer (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_start    (prog_start),
        .o_run      (),
        .o_expired  (prog_exp)
    );

    sfp_toggle_track u_toggle (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_clear    (tog_clear),
        .i_sample   (tog_sample),
        .i_bit      (i_dq_i[6]),
        .o_stable   (tog_stable)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone register slave
    assign wb_req = i_wb_cyc && i_wb_stb && !ack_q;
    assign wb_wr  = wb_req && i_wb_we;
    assign start  = wb_wr && (i_wb_adr == `SFP_REG_CMD) && i_wb_sel[0];
    assign sticky_clr = (wb_wr && (i_wb_adr == `SFP_REG_STAT) && i_wb_sel[0]) ?
                        i_wb_dat[`SFP_ST_STICKY_LSB +: 4] : 4'h0;

    always_comb begin
        status = 32'h0;
        status[`SFP_ST_BUSY]              = (state_q != sfp_pkg::ST_IDLE);
        status[`SFP_ST_LOAD_OPEN]         = lopen_q;
        status[`SFP_ST_PROG]              = prog_q;
        status[`SFP_ST_STICKY_LSB +: 4]   = sticky_q;
        status[`SFP_ST_LCNT_LSB +: 9]     = lcnt_q;
    end

    always_comb begin
        ack_d   = wb_req;
        wbd_d   = wbd_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        if (wb_req && !i_wb_we) begin
            case (i_wb_adr)
                `SFP_REG_ADDR:  wbd_d = {13'h0, addr_q};
                `SFP_REG_WDATA: wbd_d = {24'h0, wdata_q};
                `SFP_REG_STAT:  wbd_d = status;
                `SFP_REG_RDATA: wbd_d = {24'h0, rdata_q};
                default:        wbd_d = 32'h0;
            endcase
        end
        if (wb_wr && i_wb_adr == `SFP_REG_ADDR) begin
            if (i_wb_sel[0]) begin
                addr_d[7:0] = i_wb_dat[7:0];
            end
            if (i_wb_sel[1]) begin
                addr_d[15:8] = i_wb_dat[15:8];
            end
            if (i_wb_sel[2]) begin
                addr_d[18:16] = i_wb_dat[18:16];
            end
        end
        if (wb_wr && i_wb_adr == `SFP_REG_WDATA && i_wb_sel[0]) begin
            wdata_d = i_wb_dat[7:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ack_q   <= 1'b0;
            wbd_q   <= 32'h0;
            addr_q  <= `SFP_ADDR_RST;
            wdata_q <= `SFP_BYTE_RST;
        end else if (i_ce) begin
            ack_q   <= ack_d;
            wbd_q   <= wbd_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin cycle engine
    assign is_rd = (op_q == sfp_pkg::OP_READ) || (op_q == sfp_pkg::OP_POLL);

    always_comb begin
        state_d    = state_q;
        op_d       = op_q;
        cnt_d      = cnt_q;
        rdata_d    = rdata_q;
        sector_d   = sector_q;
        lcnt_d     = lcnt_q;
        lopen_d    = lopen_q;
        prog_d     = prog_q;
        ce_n_d     = ce_n_q;
        oe_n_d     = oe_n_q;
        we_n_d     = we_n_q;
        pa_d       = pa_q;
        dqo_d      = dqo_q;
        dqoe_n_d   = dqoe_n_q;
        sticky_set = 4'h0;
        win_start  = 1'b0;
        prog_start = 1'b0;
        tog_clear  = 1'b0;
        tog_sample = 1'b0;
        if (win_exp) begin
            lopen_d    = 1'b0;
            prog_d     = 1'b1;
            prog_start = 1'b1;
            if (lcnt_q != `SFP_SECTOR_BYTES) begin
                sticky_set[`SFP_FL_PARTIAL] = 1'b1;
            end
        end
        if (prog_exp) begin
            prog_d = 1'b0;
        end
        case (state_q)
            sfp_pkg::ST_IDLE: begin
                if (start) begin
                    op_d  = sfp_pkg::sfp_op_e'(i_wb_dat[1:0]);
                    pa_d  = addr_q;
                    dqo_d = wdata_q;
                    if (i_wb_dat[1:0] == sfp_pkg::OP_CMDW) begin
                        pa_d = {4'h0, addr_q[`SFP_CMD_ADDR_MSB:0]};
                    end
                    if (i_wb_dat[1:0] == sfp_pkg::OP_LOAD && lopen_q &&
                        (addr_q[18:8] != sector_q || lcnt_q == `SFP_SECTOR_BYTES)) begin
                        sticky_set[`SFP_FL_SECT_ERR] = 1'b1;
                    end else begin
                        state_d  = sfp_pkg::ST_SETUP;
                        cnt_d    = 8'(`SFP_AS_CYC - 1);
                        dqoe_n_d = i_wb_dat[1:0] == sfp_pkg::OP_READ ||
                                   i_wb_dat[1:0] == sfp_pkg::OP_POLL;
                        tog_clear = (i_wb_dat[1:0] == sfp_pkg::OP_POLL);
                        if (i_wb_dat[1:0] == sfp_pkg::OP_LOAD && !lopen_q) begin
                            sector_d = addr_q[18:8];
                            lcnt_d   = 9'h000;
                        end
                    end
                end
            end
            sfp_pkg::ST_SETUP: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    state_d = sfp_pkg::ST_STROBE;
                    ce_n_d  = 1'b0;
                    oe_n_d  = !is_rd;
                    we_n_d  = is_rd;
                    cnt_d   = is_rd ? 8'(`SFP_ACC_CYC - 1) : 8'(`SFP_WP_CYC - 1);
                end
            end
            sfp_pkg::ST_STROBE: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    state_d = sfp_pkg::ST_HOLD;
                    ce_n_d  = 1'b1;
                    oe_n_d  = 1'b1;
                    we_n_d  = 1'b1;
                    cnt_d   = 8'(`SFP_DH_CYC - 1);
                    if (is_rd) begin
                        rdata_d    = i_dq_i;
                        tog_sample = (op_q == sfp_pkg::OP_POLL);
                    end
                    if (op_q == sfp_pkg::OP_LOAD) begin
                        lcnt_d    = lcnt_q + 9'h001;
                        lopen_d   = 1'b1;
                        win_start = 1'b1;
                    end
                end
            end
            sfp_pkg::ST_HOLD: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    state_d  = sfp_pkg::ST_REC;
                    dqoe_n_d = 1'b1;
                    cnt_d    = is_rd ? 8'(`SFP_OEHP_CYC - 1) : 8'(`SFP_WPH_CYC - 1);
                end
            end
            sfp_pkg::ST_REC: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    state_d = sfp_pkg::ST_IDLE;
                    if (op_q == sfp_pkg::OP_POLL) begin
                        if (tog_stable) begin
                            sticky_set[`SFP_FL_DONE] = 1'b1;
                            prog_d = 1'b0;
                        end else if (!prog_q) begin
                            sticky_set[`SFP_FL_TMO] = 1'b1;
                        end else begin
                            state_d = sfp_pkg::ST_SETUP;
                            cnt_d   = 8'(`SFP_AS_CYC - 1);
                        end
                    end
                end
            end
            default: begin
                state_d = sfp_pkg::ST_IDLE;
            end
        endcase
        sticky_d = (sticky_q & ~sticky_clr) | sticky_set;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_q  <= sfp_pkg::ST_IDLE;
            op_q     <= sfp_pkg::OP_READ;
            cnt_q    <= 8'h00;
            rdata_q  <= `SFP_BYTE_RST;
            sector_q <= 11'h000;
            lcnt_q   <= 9'h000;
            lopen_q  <= 1'b0;
            prog_q   <= 1'b0;
            sticky_q <= `SFP_STICKY_RST;
            ce_n_q   <= 1'b1;
            oe_n_q   <= 1'b1;
            we_n_q   <= 1'b1;
            pa_q     <= `SFP_ADDR_RST;
            dqo_q    <= `SFP_BYTE_RST;
            dqoe_n_q <= 1'b1;
        end else if (i_ce) begin
            state_q  <= state_d;
            op_q     <= op_d;
            cnt_q    <= cnt_d;
            rdata_q  <= rdata_d;
            sector_q <= sector_d;
            lcnt_q   <= lcnt_d;
            lopen_q  <= lopen_d;
            prog_q   <= prog_d;
            sticky_q <= sticky_d;
            ce_n_q   <= ce_n_d;
            oe_n_q   <= oe_n_d;
            we_n_q   <= we_n_d;
            pa_q     <= pa_d;
            dqo_q    <= dqo_d;
            dqoe_n_q <= dqoe_n_d;
        end
    end

    assign o_wb_dat  = wbd_q;
    assign o_wb_ack  = ack_q;
    assign o_ce_n    = ce_n_q;
    assign o_oe_n    = oe_n_q;
    assign o_we_n    = we_n_q;
    assign o_addr    = pa_q;
    assign o_dq_o    = dqo_q;
    assign o_dq_oe_n = dqoe_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [5:0] oe_hi_q;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            oe_hi_q <= 6'h3f;
        end else if (i_ce) begin
            oe_hi_q <= !oe_n_q ? 6'h00 : (oe_hi_q == 6'h3f ? oe_hi_q : oe_hi_q + 6'h01);
        end
    end

    chk_sector_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(o_we_n) && op_q == sfp_pkg::OP_LOAD |-> o_addr[18:8] == sector_q)
        else $error("load strobe outside latched sector");
    chk_oe_high: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_we_n || !o_ce_n && op_q != sfp_pkg::OP_READ && op_q != sfp_pkg::OP_POLL |-> o_oe_n)
        else $error("output enable low during write");
    chk_partial_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_ce && win_exp && lcnt_q != `SFP_SECTOR_BYTES |=> sticky_q[`SFP_FL_PARTIAL])
        else $error("short sector not flagged");
    chk_window_close: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_ce && win_exp |=> !lopen_q && prog_q)
        else $error("load window did not close into programming");
    chk_cmd_addr: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_we_n && op_q == sfp_pkg::OP_CMDW |-> o_addr[18:15] == 4'h0)
        else $error("command address uses upper lines");
    chk_sector_cap: assert property (@(posedge i_core_clk) disable iff (i_rst)
        lcnt_q <= `SFP_SECTOR_BYTES)
        else $error("more loads than a sector holds");
    chk_poll_gap: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(o_oe_n) |-> oe_hi_q >= 6'(`SFP_OEHP_CYC))
        else $error("read strobe high time too short");
    chk_poll_addr: assert property (@(posedge i_core_clk) disable iff (i_rst)
        op_q == sfp_pkg::OP_POLL && $past(state_q) != sfp_pkg::ST_IDLE |-> $stable(o_addr))
        else $error("poll address changed");

    cov_full_sector: cover property (@(posedge i_core_clk) disable iff (i_rst)
        win_exp && lcnt_q == `SFP_SECTOR_BYTES);
    cov_poll_done: cover property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(sticky_q[`SFP_FL_DONE]));
    cov_poll_tmo: cover property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(sticky_q[`SFP_FL_TMO]));
    cov_sect_err: cover property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(sticky_q[`SFP_FL_SECT_ERR]));
endmodule

/* sfp_flash_model.sv */
// Behavioural model of the parallel sector flash behind the controller
module sfp_flash_model #(
    parameter int         WIN_CYC  = 200,
    parameter int         PROG_CYC = 2000,
    parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
    parameter logic [7:0] PART_ID  = 8'hc3  // Arbitrary value
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic [18:0] i_addr,
    input  wire logic [7:0]  i_dq,
    output logic      [7:0]  o_dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [int];
    logic [7:0]  page [int];
    logic [10:0] sect = 11'h000;
    logic [22:0] h0 = 23'h0;
    logic [22:0] h1 = 23'h0;
    logic [7:0]  last_q = 8'h00;
    logic        wr_q = 1'b0, rd_q = 1'b0, tog = 1'b0, b7 = 1'b0, idm = 1'b0;
    logic        prot = 1'b0, pen = 1'b0, pdis = 1'b0, lk_lo = 1'b0, lk_hi = 1'b0;
    int          win = 0;
    int          prog = 0;
    wire         rd = !i_ce_n && !i_oe_n && i_we_n;
    ////////////////////////////////////////////////////////////////////////////////
    // Read path, released bus shows the inverse of the last value
    always @* begin
        if (!rd) o_dq = ~last_q;
        else if (prog > 0) o_dq = {~b7, tog, 6'h2a};
        else if (idm && i_addr[18:1] == 18'h0) o_dq = i_addr[0] ? PART_ID : MAKER_ID;
        else o_dq = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 8'hff;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Byte loading, command sequences and program timer
    always @(posedge i_core_clk) begin
        wr_q <= !i_ce_n && !i_we_n;
        rd_q <= rd;
        if (rd) last_q <= o_dq;
        if (rd && !rd_q && prog > 0) tog <= !tog;
        if (prog > 0) prog <= prog - 1;
        if (prog == 1) begin
            if (pen) prot <= 1'b1;
            if (pdis) prot <= 1'b0;
            pen <= 1'b0;
            pdis <= 1'b0;
        end
        if (i_rst) begin
            idm <= 1'b0;
            win <= 0;
            page.delete();
        end else if (wr_q && i_we_n) begin
            h0 <= h1;
            h1 <= {i_addr[14:0], i_dq};
            if (h0 == {15'h1111, 8'h11} && h1 == {15'h2222, 8'h22} && i_addr[14:0] == 15'h1111) begin
                case (i_dq)
                    8'h31: idm <= 1'b1;
                    8'h32: idm <= 1'b0;
                    8'h33: pen <= 1'b1;
                    8'h34: pdis <= 1'b1;
                    8'h35: lk_lo <= 1'b1;
                    8'h36: lk_hi <= 1'b1;
                    default: ;
                endcase
                page.delete();
                win <= 0;
            end else begin
                if (page.size() == 0) sect <= i_addr[18:8];
                page[int'(i_addr[7:0])] = i_dq;
                b7 <= i_dq[7];
                win <= WIN_CYC;
            end
        end else if (win == 1) begin
            if (!(prot && !pen && !pdis) && !(lk_lo && sect < 11'h040) && !(lk_hi && sect >= 11'h7c0))
                for (int k = 0; k < 256; k++)
                    mem[int'({sect, 8'(k)})] = page.exists(k) ? page[k] : 8'hxx;
            page.delete();
            win <= 0;
            prog <= PROG_CYC;
        end else if (win > 0) win <= win - 1;
    end
endmodule

/* sfp_host_ctrl_test.sv */
// Self-checking testbench of the sector flash program controller
`include "sfp_consts.svh"
module sfp_host_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WIN = 200;
    localparam int PRG = 2000;
    logic        i_core_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] got, o_wb_dat;
    logic        o_wb_ack, ce_n, oe_n, we_n, dq_oe_n;
    logic [18:0] faddr;
    logic [7:0]  dq_o, dq_dev, mem [256];
    wire  [7:0]  dq_bus = dq_oe_n ? dq_dev : dq_o;
    logic [63:0] exp_q [$];
    logic [63:0] e;
    int          seed = 32'h6f0020fa;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          d;

    sfp_host_ctrl #(.P_WINDOW_CYC(WIN), .P_PROG_CYC(PRG)) sfp_host_ctrl_i (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(faddr),
        .o_dq_o(dq_o), .o_dq_oe_n(dq_oe_n), .i_dq_i(dq_bus));
    sfp_flash_model #(.WIN_CYC(WIN), .PROG_CYC(PRG / 2)) sfp_flash_model_i (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_addr(faddr), .i_dq(dq_bus), .o_dq(dq_dev));

    initial begin
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] x, input logic [31:0] m);
        if (m != 32'h0) begin
            tests_run++;
            if ((g & m) !== (x & m)) begin
                mismatches++;
                $display("ERROR %0t read 0x%08h expected 0x%08h mask 0x%08h", $time, g, x, m);
            end
        end
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            $display("ERROR %0t run did not finish", $time);
            tally_and_finish();
        end
        if (o_wb_ack === 1'b1 && !we) begin
            e = exp_q.pop_front();
            cmp_word(o_wb_dat, e[63:32], e[31:0]);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Bus and flash access tasks
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= v;
        do @(posedge i_core_clk); while (o_wb_ack !== 1'b1);
        got = o_wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        exp_q.push_back({x, m});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_bit(input int b, input logic v);
        do rd(`SFP_REG_STAT, 32'h0, 32'h0); while (got[b] !== v);
    endtask
    task automatic op(input logic [18:0] a, input logic [7:0] v, input logic [1:0] c);
        wr(`SFP_REG_ADDR, {13'h0, a});
        wr(`SFP_REG_WDATA, {24'h0, v});
        wr(`SFP_REG_CMD, {30'h0, c});
        wait_bit(0, 1'b0);
    endtask
    task automatic fread(input logic [18:0] a, input logic [31:0] x, input logic [31:0] m);
        op(a, 8'h00, 2'h0);
        rd(`SFP_REG_RDATA, x, m);
    endtask
    task automatic seq(input logic [7:0] c);
        op(19'h79111, 8'h11, 2'h2);
        op(19'h7a222, 8'h22, 2'h2);
        op(19'h79111, c, 2'h2);
    endtask
    task automatic poll;
        wait_bit(2, 1'b1);
        wr(`SFP_REG_CMD, 32'h3);
        wait_bit(0, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        rd(`SFP_REG_ADDR, 32'h0, 32'hffffffff);
        rd(8'h20, 32'h0, 32'hffffffff);
        wr(`SFP_REG_ADDR, 32'hffffffff);
        rd(`SFP_REG_ADDR, 32'h7ffff, 32'hffffffff);
        for (int i = 0; i < 256; i++) begin
            d = $random(seed);
            mem[i] = d[7:0];
            op(19'(i + 256), d[7:0], 2'h1);
        end
        op(19'h100, 8'h00, 2'h1);
        rd(`SFP_REG_STAT, 32'h10022, 32'h1ff23);
        wr(`SFP_REG_STAT, 32'h20);
        wait_bit(2, 1'b1);
        fread(19'h1ff, {24'h0, ~mem[255][7], 7'h0}, 32'h80);
        poll();
        rd(`SFP_REG_STAT, 32'h08, 32'h7c);
        for (int i = 0; i < 256; i += 51)
            fread(19'(i + 256), {24'h0, mem[i]}, 32'hff);
        wr(`SFP_REG_STAT, 32'h78);
        op(19'h200, 8'h5a, 2'h1);
        op(19'h300, 8'ha5, 2'h1);
        rd(`SFP_REG_STAT, 32'h120, 32'h1ff20);
        poll();
        rd(`SFP_REG_STAT, 32'h48, 32'h4c);
        fread(19'h200, 32'h5a, 32'hff);
        seq(8'h31);
        fread(19'h0, 32'h5a, 32'hff);
        fread(19'h1, 32'hc3, 32'hff);
        seq(8'h32);
        fread(19'h0, 32'hff, 32'hff);
        seq(8'h35);
        op(19'h0, 8'h12, 2'h1);
        poll();
        fread(19'h0, 32'hff, 32'hff);
        seq(8'h31);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        fread(19'h0, 32'hff, 32'hff);
        tally_and_finish();
    end
endmodule
